// File: rwsc_pkg.sv
// Shared constants and types for the reset, watchdog and suspend controller.
package rwsc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned CNT_W = 32;

  localparam int unsigned T_FIRST_MS = 1;
  localparam int unsigned T_SETTLE_MS = 95;
  localparam int unsigned T_WDR_HOLD_MS = 2;
  localparam int unsigned T_WAKE_MS = 1;
  // Watchdog period is a plain default; the part's figure is not fixed here.
  localparam int unsigned T_WATCH_MS = 8;

  // Least times: round up to whole cycles.
  localparam int unsigned FIRST_CYCLES = (T_FIRST_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_CYCLES = (T_SETTLE_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WDR_HOLD_CYCLES = (T_WDR_HOLD_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CYCLES = (T_WAKE_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WATCH_CYCLES = (T_WATCH_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // I/O register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_WATCHDOG_CLEAR = 8'h26;
  localparam logic [7:0] ADDR_STATUS_CONTROL = 8'hff;

  localparam int unsigned BIT_RUN = 0;
  localparam int unsigned BIT_IE_SENSE = 2;
  localparam int unsigned BIT_SUSPEND = 3;
  localparam int unsigned BIT_POR = 4;
  localparam int unsigned BIT_BUS_RESET = 5;
  localparam int unsigned BIT_WDR = 6;

  localparam logic RUN_RST = 1'b1;
  localparam logic SUSPEND_RST = 1'b0;
  localparam logic POR_FLAG_RST = 1'b1;
  localparam logic WDR_FLAG_RST = 1'b0;
  localparam logic BUS_RESET_RST = 1'b0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ----------------------------------------------------------------
  // Synchronised inputs
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_W = 5;
  localparam int unsigned IN_POR = 0;
  localparam int unsigned IN_OSC = 1;
  localparam int unsigned IN_BUS_RESET = 2;
  localparam int unsigned IN_ACTIVITY = 3;
  localparam int unsigned IN_GPIO = 4;
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h01;

  typedef enum logic [2:0] {
    ST_POR_HOLD,
    ST_FIRST_MS,
    ST_SETTLE,
    ST_RUN,
    ST_WDR_HOLD,
    ST_SUSPEND,
    ST_WAKE_OSC,
    ST_WAKE_MS
  } rwsc_state_t;

endpackage

// File: rwsc_down_timer.sv
// Loadable down-counter that pulses once when its count runs out.
`timescale 1ns/100ps

module rwsc_down_timer (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [rwsc_pkg::CNT_W-1:0] count_i,
  input wire logic enable_i,
  output logic done_o
);

  logic [rwsc_pkg::CNT_W-1:0] remain;

  wire logic running = enable_i && (remain != '0);
  wire logic last = (remain == rwsc_pkg::CNT_W'(1));

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      remain <= '0;
    end else if (load_i) begin
      remain <= count_i;
    end else if (running) begin
      remain <= remain - rwsc_pkg::CNT_W'(1);
    end
  end

  // A load in the same cycle swallows the pulse, so a stale expiry never leaks into a new phase.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= !load_i && running && last;
    end
  end

endmodule // rwsc_down_timer

// File: rwsc_ctrl.sv
// Reset, watchdog and suspend sequencing controller with its I/O registers.
`timescale 1ns/100ps

module rwsc_ctrl #(
  parameter int unsigned FIRST_CYCLES = rwsc_pkg::FIRST_CYCLES,
  parameter int unsigned SETTLE_CYCLES = rwsc_pkg::SETTLE_CYCLES,
  parameter int unsigned WDR_HOLD_CYCLES = rwsc_pkg::WDR_HOLD_CYCLES,
  parameter int unsigned WAKE_CYCLES = rwsc_pkg::WAKE_CYCLES,
  parameter int unsigned WATCH_CYCLES = rwsc_pkg::WATCH_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic osc_stable_i,
  input wire logic usb_bus_reset_i,
  input wire logic usb_activity_i,
  input wire logic gpio_wake_i,
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic global_int_en_i,
  input wire logic bus_reset_ie_i,
  input wire logic bus_reset_ack_i,
  input wire logic instr_done_i,
  output logic [7:0] io_rdata_o,
  output logic sys_reset_o,
  output logic usb_addr_clear_o,
  output logic cpu_hold_o,
  output logic osc_run_o,
  output logic timers_run_o,
  output logic suspended_o,
  output logic int_defer_o,
  output logic usb_reset_irq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rwsc_pkg::rwsc_state_t state;
  rwsc_pkg::rwsc_state_t next_state;

  logic [rwsc_pkg::SYNC_W-1:0] in_meta;
  logic [rwsc_pkg::SYNC_W-1:0] in_sync;
  logic bus_reset_prev;

  logic run_bit;
  logic suspend_bit;
  logic por_flag;
  logic wdr_flag;
  logic bus_reset_pend;
  logic int_defer;

  logic seq_done;
  logic wdt_done;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Phase length loaded into the sequence timer when a phase begins.
  function automatic logic [rwsc_pkg::CNT_W-1:0] phase_cycles(input rwsc_pkg::rwsc_state_t st);
    logic [rwsc_pkg::CNT_W-1:0] n;
    n = '0;
    unique case (st)
      rwsc_pkg::ST_FIRST_MS: n = rwsc_pkg::CNT_W'(FIRST_CYCLES);
      rwsc_pkg::ST_SETTLE: n = rwsc_pkg::CNT_W'(SETTLE_CYCLES);
      rwsc_pkg::ST_WDR_HOLD: n = rwsc_pkg::CNT_W'(WDR_HOLD_CYCLES);
      rwsc_pkg::ST_WAKE_MS: n = rwsc_pkg::CNT_W'(WAKE_CYCLES);
      rwsc_pkg::ST_POR_HOLD,
      rwsc_pkg::ST_RUN,
      rwsc_pkg::ST_SUSPEND,
      rwsc_pkg::ST_WAKE_OSC: n = '0;
    endcase
    return n;
  endfunction

  // Phases in which the CPU and the register file are kept in reset.
  function automatic logic in_reset_phase(input rwsc_pkg::rwsc_state_t st);
    return (st == rwsc_pkg::ST_POR_HOLD) || (st == rwsc_pkg::ST_FIRST_MS) ||
           (st == rwsc_pkg::ST_SETTLE) || (st == rwsc_pkg::ST_WDR_HOLD);
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Pins and the suspend-domain wake logic are asynchronous to this clock.
  wire logic [rwsc_pkg::SYNC_W-1:0] raw_in = {gpio_wake_i, usb_activity_i, usb_bus_reset_i, osc_stable_i, por_i};

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      in_meta <= rwsc_pkg::SYNC_RST;
      in_sync <= rwsc_pkg::SYNC_RST;
    end else begin
      in_meta <= raw_in;
      in_sync <= in_meta;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bus_reset_prev <= 1'b0;
    end else begin
      bus_reset_prev <= in_sync[rwsc_pkg::IN_BUS_RESET];
    end
  end

  wire logic por_s = in_sync[rwsc_pkg::IN_POR];
  wire logic osc_s = in_sync[rwsc_pkg::IN_OSC];
  wire logic bus_reset_evt = in_sync[rwsc_pkg::IN_BUS_RESET] && !bus_reset_prev;
  wire logic wake_evt = in_sync[rwsc_pkg::IN_GPIO] || in_sync[rwsc_pkg::IN_ACTIVITY];

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire logic in_run = (state == rwsc_pkg::ST_RUN);
  wire logic wr_status = io_wr_i && (io_addr_i == rwsc_pkg::ADDR_STATUS_CONTROL);
  wire logic wr_wdt_clear = io_wr_i && (io_addr_i == rwsc_pkg::ADDR_WATCHDOG_CLEAR);
  wire logic rd_status = io_rd_i && (io_addr_i == rwsc_pkg::ADDR_STATUS_CONTROL);
  wire logic enter_suspend = wr_status && in_run && io_wdata_i[rwsc_pkg::BIT_SUSPEND];
  wire logic wdr_event = in_run && wdt_done;
  wire logic wake_done = (state == rwsc_pkg::ST_WAKE_MS) && seq_done;

  // Interrupt enable sense reflects the CPU's global enable, so a watchdog reset reads it back as zero.
  wire logic [7:0] status_value = {1'b0, wdr_flag, bus_reset_pend, por_flag, suspend_bit,
                                   global_int_en_i, 1'b0, run_bit};

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      rwsc_pkg::ST_POR_HOLD: begin
        if (!por_s && osc_s) begin
          next_state = rwsc_pkg::ST_FIRST_MS;
        end
      end
      rwsc_pkg::ST_FIRST_MS: begin
        // Bus resets are ignored here; this first stretch cannot be cut short.
        if (seq_done) begin
          next_state = rwsc_pkg::ST_SETTLE;
        end
      end
      rwsc_pkg::ST_SETTLE: begin
        if (bus_reset_evt || seq_done) begin
          next_state = rwsc_pkg::ST_RUN;
        end
      end
      rwsc_pkg::ST_RUN: begin
        if (wdt_done) begin
          next_state = rwsc_pkg::ST_WDR_HOLD;
        end else if (enter_suspend) begin
          next_state = rwsc_pkg::ST_SUSPEND;
        end
      end
      rwsc_pkg::ST_WDR_HOLD: begin
        if (seq_done) begin
          next_state = rwsc_pkg::ST_RUN;
        end
      end
      rwsc_pkg::ST_SUSPEND: begin
        if (wake_evt) begin
          next_state = rwsc_pkg::ST_WAKE_OSC;
        end
      end
      rwsc_pkg::ST_WAKE_OSC: begin
        if (osc_s) begin
          next_state = rwsc_pkg::ST_WAKE_MS;
        end
      end
      rwsc_pkg::ST_WAKE_MS: begin
        if (seq_done) begin
          next_state = rwsc_pkg::ST_RUN;
        end
      end
    endcase
    // A returning power-on indication overrides everything and starts afresh.
    if (por_s) begin
      next_state = rwsc_pkg::ST_POR_HOLD;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= rwsc_pkg::ST_POR_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  wire logic seq_load = (next_state != state);
  wire logic [rwsc_pkg::CNT_W-1:0] seq_count = phase_cycles(next_state);

  rwsc_down_timer u_seq_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .load_i(seq_load),
    .count_i(seq_count),
    .enable_i(1'b1),
    .done_o(seq_done)
  );

  // The watchdog only runs in the run state; it is reloaded in every other phase, suspend included.
  wire logic wdt_load = !in_run || wr_wdt_clear || seq_load;
  wire logic [rwsc_pkg::CNT_W-1:0] wdt_count = rwsc_pkg::CNT_W'(WATCH_CYCLES);

  rwsc_down_timer u_watchdog (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .load_i(wdt_load),
    .count_i(wdt_count),
    .enable_i(in_run),
    .done_o(wdt_done)
  );

  // ----------------------------------------------------------------
  // Status and control flags
  // ----------------------------------------------------------------
  // Hardware sets win over a firmware write of zero in the same cycle.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      por_flag <= rwsc_pkg::POR_FLAG_RST;
    end else if (por_s) begin
      por_flag <= 1'b1;
    end else if (wr_status) begin
      por_flag <= por_flag && io_wdata_i[rwsc_pkg::BIT_POR];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wdr_flag <= rwsc_pkg::WDR_FLAG_RST;
    end else if (wdr_event) begin
      wdr_flag <= 1'b1;
    end else if (wr_status) begin
      wdr_flag <= wdr_flag && io_wdata_i[rwsc_pkg::BIT_WDR];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      run_bit <= rwsc_pkg::RUN_RST;
    end else if (por_s || wdr_event) begin
      run_bit <= 1'b1;
    end else if (wr_status) begin
      run_bit <= io_wdata_i[rwsc_pkg::BIT_RUN];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      suspend_bit <= rwsc_pkg::SUSPEND_RST;
    end else if (por_s || wdr_event || wake_evt) begin
      suspend_bit <= 1'b0;
    end else if (wr_status && in_run) begin
      suspend_bit <= io_wdata_i[rwsc_pkg::BIT_SUSPEND];
    end
  end

  // A bus reset cutting the settle wait short stays pending; the CPU reset does not clear it.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bus_reset_pend <= rwsc_pkg::BUS_RESET_RST;
    end else if (bus_reset_evt && !in_reset_phase(state)) begin
      bus_reset_pend <= 1'b1;
    end else if (bus_reset_evt && state == rwsc_pkg::ST_SETTLE) begin
      bus_reset_pend <= 1'b1;
    end else if (wdr_event || por_s || bus_reset_ack_i) begin
      bus_reset_pend <= 1'b0;
    end
  end

  // After a wake, interrupts wait until the instruction after the suspending write retires.
  // The output register takes the same next value, so the pin never lags the gate it reports.
  wire logic next_defer = wake_done || (int_defer && !instr_done_i && in_run);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      int_defer <= 1'b0;
    end else begin
      int_defer <= next_defer;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire logic next_reset = in_reset_phase(next_state);
  wire logic next_suspend = (next_state == rwsc_pkg::ST_SUSPEND);
  wire logic next_hold = (next_state != rwsc_pkg::ST_RUN) || !run_bit;
  wire logic next_irq = bus_reset_pend && bus_reset_ie_i && global_int_en_i && !int_defer && in_run;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sys_reset_o <= 1'b1;
      usb_addr_clear_o <= 1'b1;
      cpu_hold_o <= 1'b1;
    end else begin
      sys_reset_o <= next_reset;
      usb_addr_clear_o <= next_reset;
      cpu_hold_o <= next_hold;
    end
  end

  // The oscillator restarts as soon as a wake is seen, ahead of the settle time.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      osc_run_o <= 1'b1;
      timers_run_o <= 1'b1;
      suspended_o <= 1'b0;
    end else begin
      osc_run_o <= !next_suspend;
      timers_run_o <= !next_suspend;
      suspended_o <= next_suspend;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      int_defer_o <= 1'b0;
      usb_reset_irq_o <= 1'b0;
    end else begin
      int_defer_o <= next_defer;
      usb_reset_irq_o <= next_irq;
    end
  end

  // The watchdog clear register is write-only and reads as zero like every address except the status and control register.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      io_rdata_o <= rwsc_pkg::RDATA_RST;
    end else if (rd_status) begin
      io_rdata_o <= status_value;
    end else begin
      io_rdata_o <= rwsc_pkg::RDATA_RST;
    end
  end

endmodule // rwsc_ctrl

// File: rwsc_osc_cpu_model.sv
// Oscillator and CPU model that stands across from the controller.
`timescale 1ns/100ps

module rwsc_osc_cpu_model #(
  parameter int unsigned OSC_START = 5
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic osc_run_i,
  input wire logic cpu_hold_i,
  output logic osc_stable_o,
  output logic instr_done_o
);
  // ----------------------------------------------------------------
  // Behaviour
  // ----------------------------------------------------------------
  // The oscillator takes a few cycles after each restart, so a wake can never look instant.
  int unsigned osc_cnt;
  logic [1:0] phase;
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      osc_cnt <= 0;
      osc_stable_o <= 1'b0;
      phase <= 2'h0;
      instr_done_o <= 1'b0;
    end else begin
      osc_cnt <= osc_run_i ? ((osc_cnt < OSC_START) ? osc_cnt + 1 : osc_cnt) : 0;
      osc_stable_o <= osc_run_i && (osc_cnt >= OSC_START);
      phase <= phase + 2'h1;
      instr_done_o <= !cpu_hold_i && (phase == 2'h3);
    end
  end
endmodule // rwsc_osc_cpu_model

// File: rwsc_ctrl_asserts.sv
// Concurrent checks on the ports of the controller.
`timescale 1ns/100ps

module rwsc_ctrl_chk (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic usb_activity_i,
  input wire logic gpio_wake_i,
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic global_int_en_i,
  input wire logic bus_reset_ie_i,
  input wire logic instr_done_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic sys_reset_o,
  input wire logic usb_addr_clear_o,
  input wire logic cpu_hold_o,
  input wire logic osc_run_o,
  input wire logic timers_run_o,
  input wire logic suspended_o,
  input wire logic int_defer_o,
  input wire logic usb_reset_irq_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence quiet_s;
    (suspended_o && !gpio_wake_i && !usb_activity_i && !por_i)[*4];
  endsequence
  sequence wake_exit_s;
    $fell(suspended_o) && !sys_reset_o;
  endsequence
  sequence suspend_req_s;
    io_wr_i && io_addr_i == 8'hff && io_wdata_i[3] && !cpu_hold_o && !por_i;
  endsequence
  reset_pair_a: assert property (usb_addr_clear_o == sys_reset_o) else $error("address clear differs from reset");
  hold_reset_a: assert property (sys_reset_o |-> cpu_hold_o) else $error("cpu runs in reset");
  suspend_entry_a: assert property (suspend_req_s |-> ##[1:2] suspended_o) else $error("suspend not entered");
  suspend_off_a: assert property (suspended_o |-> !osc_run_o && !timers_run_o && cpu_hold_o) else $error("clock on");
  wake_source_a: assert property (quiet_s |=> suspended_o) else $error("wake without cause");
  osc_restart_a: assert property (wake_exit_s |-> ##[0:1] osc_run_o) else $error("oscillator not restarted");
  wake_hold_a: assert property (wake_exit_s |-> cpu_hold_o[*8]) else $error("cpu ran too soon after wake");
  irq_gate_a: assert property (usb_reset_irq_o |->
    $past(bus_reset_ie_i && global_int_en_i && !int_defer_o)) else $error("irq not gated");
  defer_clear_a: assert property (int_defer_o && instr_done_i |=> !int_defer_o) else $error("defer stuck");
  read_idle_a: assert property (!$past(io_rd_i) |-> io_rdata_o == 8'h00) else $error("read data not idle");
  status_read_a: assert property ($past(io_rd_i && io_addr_i == 8'hff) |->
    !io_rdata_o[7] && !io_rdata_o[1] && io_rdata_o[2] == $past(global_int_en_i)) else $error("bad status");
endmodule // rwsc_ctrl_chk

bind rwsc_ctrl rwsc_ctrl_chk i_rwsc_ctrl_chk (.clock_i(clock_i), .rst_i(rst_i), .por_i(por_i),
  .usb_activity_i(usb_activity_i), .gpio_wake_i(gpio_wake_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
  .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .global_int_en_i(global_int_en_i), .bus_reset_ie_i(bus_reset_ie_i),
  .instr_done_i(instr_done_i), .io_rdata_o(io_rdata_o), .sys_reset_o(sys_reset_o),
  .usb_addr_clear_o(usb_addr_clear_o), .cpu_hold_o(cpu_hold_o), .osc_run_o(osc_run_o),
  .timers_run_o(timers_run_o), .suspended_o(suspended_o), .int_defer_o(int_defer_o),
  .usb_reset_irq_o(usb_reset_irq_o));

// File: tb.sv
// Self-checking testbench for the reset, watchdog and suspend controller.
`timescale 1ns/100ps

module tb;
  // ----------------------------------------------------------------
  // Bench setup
  // ----------------------------------------------------------------
  // Short counts keep the run brief; each phase-length window is derived from them.
  localparam int FIRST = 20;
  localparam int SETTLE = 50;
  localparam int HOLD = 30;
  localparam int WAKE = 20;
  localparam int WATCH = 40;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic por_i = 1'b1;
  logic usb_bus_reset_i = 1'b0;
  logic usb_activity_i = 1'b0;
  logic gpio_wake_i = 1'b0;
  logic [7:0] io_addr_i = 8'h00;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic global_int_en_i = 1'b0;
  logic bus_reset_ie_i = 1'b0;
  logic bus_reset_ack_i = 1'b0;
  logic osc_stable_i, instr_done_i, sys_reset_o, usb_addr_clear_o, cpu_hold_o, osc_run_o;
  logic timers_run_o, suspended_o, int_defer_o, usb_reset_irq_o;
  logic [7:0] io_rdata_o;
  logic [7:0] d;
  int n;
  int fails = 0;
  int checks_done = 0;
  always #5 clock_i = ~clock_i;

  rwsc_ctrl #(.FIRST_CYCLES(FIRST), .SETTLE_CYCLES(SETTLE), .WDR_HOLD_CYCLES(HOLD), .WAKE_CYCLES(WAKE),
    .WATCH_CYCLES(WATCH)) i_rwsc_ctrl (.clock_i(clock_i), .rst_i(rst_i), .por_i(por_i),
    .osc_stable_i(osc_stable_i), .usb_bus_reset_i(usb_bus_reset_i), .usb_activity_i(usb_activity_i),
    .gpio_wake_i(gpio_wake_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
    .io_wdata_i(io_wdata_i), .global_int_en_i(global_int_en_i), .bus_reset_ie_i(bus_reset_ie_i),
    .bus_reset_ack_i(bus_reset_ack_i), .instr_done_i(instr_done_i), .io_rdata_o(io_rdata_o),
    .sys_reset_o(sys_reset_o), .usb_addr_clear_o(usb_addr_clear_o), .cpu_hold_o(cpu_hold_o),
    .osc_run_o(osc_run_o), .timers_run_o(timers_run_o), .suspended_o(suspended_o),
    .int_defer_o(int_defer_o), .usb_reset_irq_o(usb_reset_irq_o));
  rwsc_osc_cpu_model i_rwsc_osc_cpu_model (.clock_i(clock_i), .rst_i(rst_i), .osc_run_i(osc_run_o),
    .cpu_hold_i(cpu_hold_o), .osc_stable_o(osc_stable_i), .instr_done_o(instr_done_i));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task chkn(input int cnt, input int lo, input int hi);
    checks_done++;
    if (cnt < lo || cnt > hi) begin
      fails++;
      $display("unexpected at %0t: count %0d outside %0d to %0d", $time, cnt, lo, hi);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock_i);
    io_addr_i = a;
    io_wdata_i = v;
    io_wr_i = 1'b1;
    @(negedge clock_i);
    io_wr_i = 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clock_i);
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(negedge clock_i);
    io_rd_i = 1'b0;
    v = io_rdata_o;
  endtask
  // Waiting is bounded, so a stuck sequencer shows up as a count out of range.
  task wait_for(input int sel, input logic lvl, output int cnt);
    logic s;
    cnt = 0;
    do begin
      @(negedge clock_i);
      cnt++;
      s = (sel == 0) ? sys_reset_o : ((sel == 1) ? cpu_hold_o : osc_run_o);
    end while (s !== lvl && cnt < 400);
  endtask
  task do_por();
    por_i = 1'b1;
    repeat (4) @(negedge clock_i);
    chk8({5'h00, sys_reset_o, usb_addr_clear_o, cpu_hold_o}, 8'h07);
    por_i = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_por();
    do_por();
    wait_for(0, 1'b0, n);
    chkn(n, FIRST + SETTLE, FIRST + SETTLE + 8);
    rd(8'hff, d);
    chk8(d, 8'h11);
    rd(8'h26, d);
    chk8(d, 8'h00);
  endtask
  task t_wdt();
    wr(8'h26, 8'h00);
    wr(8'hff, 8'h01);
    for (int i = 1; i < 4; i++) begin
      repeat (30) @(negedge clock_i);
      wr(8'h26, 8'h55 * i[7:0]);
      chk8({7'h00, sys_reset_o}, 8'h00);
    end
    wait_for(0, 1'b1, n);
    chkn(n, WATCH - 3, WATCH + 6);
    chk8({7'h00, usb_addr_clear_o}, 8'h01);
    wait_for(0, 1'b0, n);
    chkn(n, HOLD - 2, HOLD + 4);
    rd(8'hff, d);
    chk8(d, 8'h41);
    wr(8'hff, 8'h00);
    @(negedge clock_i);
    chk8({7'h00, cpu_hold_o}, 8'h01);
    wr(8'hff, 8'h01);
  endtask
  task t_bus();
    do_por();
    repeat (5) @(negedge clock_i);
    usb_bus_reset_i = 1'b1;
    repeat (4) @(negedge clock_i);
    usb_bus_reset_i = 1'b0;
    chk8({7'h00, sys_reset_o}, 8'h01);
    repeat (FIRST + 1) @(negedge clock_i);
    usb_bus_reset_i = 1'b1;
    wait_for(0, 1'b0, n);
    chkn(n, 1, 6);
    usb_bus_reset_i = 1'b0;
    rd(8'hff, d);
    chk8(d & 8'h20, 8'h20);
    bus_reset_ie_i = 1'b1;
    repeat (3) @(negedge clock_i);
    chk8({7'h00, usb_reset_irq_o}, 8'h00);
    global_int_en_i = 1'b1;
    repeat (3) @(negedge clock_i);
    chk8({7'h00, usb_reset_irq_o}, 8'h01);
    bus_reset_ack_i = 1'b1;
    @(negedge clock_i);
    bus_reset_ack_i = 1'b0;
    repeat (3) @(negedge clock_i);
    chk8({7'h00, usb_reset_irq_o}, 8'h00);
    global_int_en_i = 1'b0;
    bus_reset_ie_i = 1'b0;
  endtask
  task t_susp(input int src);
    do_por();
    wait_for(0, 1'b0, n);
    wr(8'hff, 8'h09);
    @(negedge clock_i);
    chk8({5'h00, suspended_o, osc_run_o, timers_run_o}, 8'h04);
    repeat (WATCH + 20) @(negedge clock_i);
    chk8({6'h00, suspended_o, sys_reset_o}, 8'h02);
    if (src == 0) gpio_wake_i = 1'b1;
    else usb_activity_i = 1'b1;
    wait_for(2, 1'b1, n);
    chkn(n, 1, 5);
    gpio_wake_i = 1'b0;
    usb_activity_i = 1'b0;
    wait_for(1, 1'b0, n);
    chkn(n, WAKE + 5, WAKE + 14);
    chk8({7'h00, int_defer_o}, 8'h01);
    repeat (6) @(negedge clock_i);
    chk8({7'h00, int_defer_o}, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task results();
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clock_i);
    rst_i = 1'b0;
    t_por();
    t_wdt();
    t_bus();
    t_susp(0);
    t_susp(1);
    results();
  end
  initial begin
    #100000;
    fails++;
    results();
  end
endmodule // tb
